// ===== src/tbt_ber_tester.sv
`timescale 1ns/1ns
`include "tbt_regs.svh"
module tbt_ber_tester
   import tbt_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int CNT_W = 16,
   parameter int FIFO_DEPTH = `TBT_FIFO_DEPTH,
   parameter logic [22:0] SEED = `TBT_SEED
) (
   input wire logic clk_i, // system clock, 250 MHz
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic ce_i, // clock enable, freezes all state when low
   input wire logic [ADDR_W-1:0] addr_i, // register address
   input wire logic [15:0] wdata_i, // register write data
   input wire logic wr_en_i, // register write strobe
   input wire logic rd_en_i, // register read strobe
   output logic [15:0] rdata_o, // register read data
   input wire logic bp_rx_bit_i, // backplane received bit, pin
   input wire logic bp_rx_stb_i, // backplane bit strobe, pin
   input wire logic loc_rx_bit_i, // local received bit, pin
   input wire logic loc_rx_stb_i, // local bit strobe, pin
   input wire logic bp_tx_ready_i, // backplane slot takes a bit
   input wire logic loc_tx_ready_i, // local slot takes a bit
   output logic bp_tx_bit_o, // backplane test bit
   output logic bp_tx_valid_o, // backplane test bit valid
   output logic loc_tx_bit_o, // local test bit
   output logic loc_tx_valid_o, // local test bit valid
   output logic [CNT_W-1:0] bp_error_count_o, // backplane error count
   output logic [CNT_W-1:0] loc_error_count_o, // local error count
   output logic bp_rx_locked_o, // backplane lock flag
   output logic loc_rx_locked_o // local lock flag
);

   // port index 0 is local, 1 is backplane
   localparam int NP = 2;
   localparam int FW = `TBT_FLD_W;
   localparam int SW = `TBT_SEQ_W;

   generate
      if (CNT_W < 1 || CNT_W > 32 || FIFO_DEPTH < 2 || ADDR_W < 2) begin : g_bad
         $error("tbt_ber_tester: unsupported parameter values");
      end
      if (SEED[14:0] == 15'h0000) begin : g_bad_seed
         $error("tbt_ber_tester: seed must be nonzero in both lengths");
      end
   endgenerate

   // next sequence bit from a window of past bits, index 0 newest
   function automatic logic prbs_fb(input logic [SW-1:0] w, input logic long);
      prbs_fb = long ? (w[`TBT_LONG_TAP_A] ^ w[`TBT_LONG_TAP_B])
                     : (w[`TBT_SHORT_TAP_A] ^ w[`TBT_SHORT_TAP_B]);
   endfunction

   // oldest bit of the window, the one the generator sends next
   function automatic logic prbs_oldest(input logic [SW-1:0] w, input logic long);
      prbs_oldest = long ? w[SW-1] : w[`TBT_SHORT_TAP_A];
   endfunction

   // true when the window holds the seed for the chosen length
   function automatic logic seed_match(input logic [SW-1:0] w, input logic long);
      seed_match = long ? (w == SEED) : (w[14:0] == SEED[14:0]);
   endfunction

   // register state
   logic [15:0] ctrl_reg;
   logic [15:0] rdata_reg;
   logic wr_hit;
   logic rd_hit;
   logic [FW-1:0] rise [NP];
   logic [FW-1:0] fld [NP];

   // transmit state
   logic [SW-1:0] gen_reg [NP];
   logic tx_run_reg [NP];
   logic tx_bit_reg [NP];
   logic tx_valid_reg [NP];
   logic push_valid [NP];
   logic push_ready [NP];
   logic push_data [NP];
   logic head_valid [NP];
   logic head_data [NP];
   logic head_pop [NP];
   logic tx_ready [NP];

   // receive state
   logic rx_in [NP];
   logic stb_in [NP];
   logic bit_s1_reg [NP];
   logic bit_s2_reg [NP];
   logic stb_s1_reg [NP];
   logic stb_s2_reg [NP];
   logic stb_s3_reg [NP];
   logic take [NP];
   tbt_rx_state_t rx_state_reg [NP];
   logic [SW-1:0] win_reg [NP];
   logic [SW-1:0] win_next [NP];
   logic [SW-1:0] ref_reg [NP];
   logic expect_bit [NP];
   logic mismatch [NP];
   logic lock_reg [NP];
   logic [CNT_W-1:0] cnt_reg [NP];
   logic [CNT_W-1:0] count_reg [NP];

   // map pins onto the port arrays
   assign rx_in[0] = loc_rx_bit_i;
   assign rx_in[1] = bp_rx_bit_i;
   assign stb_in[0] = loc_rx_stb_i;
   assign stb_in[1] = bp_rx_stb_i;
   assign tx_ready[0] = loc_tx_ready_i;
   assign tx_ready[1] = bp_tx_ready_i;

   // address decode for the single control register
   always_comb begin
      wr_hit = 1'b0;
      rd_hit = 1'b0;
      if (addr_i == ADDR_W'(`TBT_CTRL_OFFSET)) begin
         wr_hit = wr_en_i;
         rd_hit = rd_en_i;
      end else begin
         wr_hit = 1'b0;
         rd_hit = 1'b0;
      end
   end

   // per-port fields and zero-to-one detection on a write
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         fld[p] = ctrl_reg[p*FW +: FW];
         rise[p] = wr_hit ? (wdata_i[p*FW +: FW] & ~ctrl_reg[p*FW +: FW]) : '0;
      end
   end

   // control register; lock flags and reserved bits are never stored
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= `TBT_CTRL_RESET;
      end else if (ce_i && wr_hit) begin
         ctrl_reg <= wdata_i & `TBT_CTRL_WMASK;
      end
   end

   // read data is registered; an unmapped address reads zero
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_reg <= '0;
      end else if (ce_i && rd_en_i) begin
         if (rd_hit) begin
            rdata_reg <= (ctrl_reg & `TBT_CTRL_WMASK)
               | (16'(lock_reg[1]) << (`TBT_BP_BASE + `TBT_F_LOCK))
               | (16'(lock_reg[0]) << (`TBT_LOC_BASE + `TBT_F_LOCK));
         end else begin
            rdata_reg <= '0;
         end
      end
   end

   // transmit run flag: started by a rise, stopped while the bit is low
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            tx_run_reg[p] <= 1'b0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            if (rise[p][`TBT_F_TXS]) begin
               tx_run_reg[p] <= 1'b1;
            end else if (!fld[p][`TBT_F_TXS]) begin
               tx_run_reg[p] <= 1'b0;
            end
         end
      end
   end

   // generator pushes into the buffer; a full buffer stalls the sequence
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         push_valid[p] = tx_run_reg[p] && !rise[p][`TBT_F_SEED];
         push_data[p] = prbs_oldest(gen_reg[p], fld[p][`TBT_F_LEN]);
      end
   end

   // generator window, oldest bit leaves first so the seed goes out first
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            gen_reg[p] <= SEED;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            if (rise[p][`TBT_F_SEED]) begin
               gen_reg[p] <= SEED;
            end else if (push_valid[p] && push_ready[p]) begin
               gen_reg[p] <= {gen_reg[p][SW-2:0], prbs_fb(gen_reg[p], fld[p][`TBT_F_LEN])};
            end
         end
      end
   end

   // one buffer per port between generator and serial slot
   for (genvar g = 0; g < NP; g++) begin : g_fifo
      tbt_fifo #(
         .WIDTH(1),
         .DEPTH(FIFO_DEPTH)
      ) u_fifo (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .ce_i(ce_i),
         .in_valid_i(push_valid[g]),
         .in_data_i(push_data[g]),
         .in_ready_o(push_ready[g]),
         .out_valid_o(head_valid[g]),
         .out_data_o(head_data[g]),
         .out_ready_i(head_pop[g])
      );
   end

   // a slot takes the head bit only when one is waiting
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         head_pop[p] = tx_ready[p] && head_valid[p];
      end
   end

   // output bit register; valid is a one-cycle pulse per bit
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            tx_bit_reg[p] <= 1'b0;
            tx_valid_reg[p] <= 1'b0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            tx_valid_reg[p] <= head_pop[p];
            if (head_pop[p]) begin
               tx_bit_reg[p] <= head_data[p];
            end
         end
      end
   end

   // two-flop synchronisers on the pin inputs, plus an edge stage on the strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            bit_s1_reg[p] <= 1'b0;
            bit_s2_reg[p] <= 1'b0;
            stb_s1_reg[p] <= 1'b0;
            stb_s2_reg[p] <= 1'b0;
            stb_s3_reg[p] <= 1'b0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            bit_s1_reg[p] <= rx_in[p];
            bit_s2_reg[p] <= bit_s1_reg[p];
            stb_s1_reg[p] <= stb_in[p];
            stb_s2_reg[p] <= stb_s1_reg[p];
            stb_s3_reg[p] <= stb_s2_reg[p];
         end
      end
   end

   // one received bit per strobe rise; reference predicts the next bit
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         take[p] = stb_s2_reg[p] && !stb_s3_reg[p];
         win_next[p] = {win_reg[p][SW-2:0], bit_s2_reg[p]};
         expect_bit[p] = prbs_fb(ref_reg[p], fld[p][`TBT_F_LEN]);
         // compare only when locked and enabled
         mismatch[p] = take[p] && (rx_state_reg[p] == TBT_RX_LOCK) && fld[p][`TBT_F_RXS]
                       && !rise[p][`TBT_F_RXS] && (expect_bit[p] != bit_s2_reg[p]);
      end
   end

   // checker state machine: idle, hunting for the seed, locked
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            rx_state_reg[p] <= TBT_RX_IDLE;
            win_reg[p] <= '0;
            ref_reg[p] <= '0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            if (rise[p][`TBT_F_RXS]) begin
               rx_state_reg[p] <= TBT_RX_HUNT;
               win_reg[p] <= '0;
            end else if (!fld[p][`TBT_F_RXS]) begin
               rx_state_reg[p] <= TBT_RX_IDLE;
            end else if (take[p]) begin
               case (rx_state_reg[p])
                  TBT_RX_HUNT: begin
                     win_reg[p] <= win_next[p];
                     if (seed_match(win_next[p], fld[p][`TBT_F_LEN])) begin
                        rx_state_reg[p] <= TBT_RX_LOCK;
                        ref_reg[p] <= win_next[p];
                     end
                  end
                  TBT_RX_LOCK: begin
                     // reference free-runs so line errors do not spread
                     ref_reg[p] <= {ref_reg[p][SW-2:0], expect_bit[p]};
                  end
                  default: begin
                     rx_state_reg[p] <= TBT_RX_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // lock flag: set on seed found, cleared only by a receiver start rise
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            lock_reg[p] <= 1'b0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            if (rise[p][`TBT_F_RXS]) begin
               lock_reg[p] <= 1'b0;
            end else if (fld[p][`TBT_F_RXS] && take[p] && rx_state_reg[p] == TBT_RX_HUNT
                         && seed_match(win_next[p], fld[p][`TBT_F_LEN])) begin
               lock_reg[p] <= 1'b1;
            end
         end
      end
   end

   // internal mismatch counter saturates; an error beside a clear still counts
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            cnt_reg[p] <= '0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            if (rise[p][`TBT_F_CLR]) begin
               cnt_reg[p] <= CNT_W'(mismatch[p]);
            end else if (mismatch[p] && cnt_reg[p] != '1) begin
               cnt_reg[p] <= cnt_reg[p] + 1'b1;
            end
         end
      end
   end

   // visible count follows the internal counter one cycle later
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NP; p++) begin
            count_reg[p] <= '0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++) begin
            if (rise[p][`TBT_F_CLR]) begin
               count_reg[p] <= '0;
            end else begin
               count_reg[p] <= cnt_reg[p];
            end
         end
      end
   end

   // outputs, all straight from flops
   assign rdata_o = rdata_reg;
   assign bp_tx_bit_o = tx_bit_reg[1];
   assign bp_tx_valid_o = tx_valid_reg[1];
   assign loc_tx_bit_o = tx_bit_reg[0];
   assign loc_tx_valid_o = tx_valid_reg[0];
   assign bp_error_count_o = count_reg[1];
   assign loc_error_count_o = count_reg[0];
   assign bp_rx_locked_o = lock_reg[1];
   assign loc_rx_locked_o = lock_reg[0];

endmodule

// ===== src/tbt_fifo.sv
`timescale 1ns/1ns
module tbt_fifo
   import tbt_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic ce_i, // clock enable, freezes state when low
   input wire logic in_valid_i, // write request
   input wire logic [WIDTH-1:0] in_data_i, // write data
   output logic in_ready_o, // not full
   output logic out_valid_o, // not empty
   output logic [WIDTH-1:0] out_data_o, // head word
   input wire logic out_ready_i // read accept
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad
         $error("tbt_fifo: DEPTH must be at least 2 and WIDTH at least 1");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // handshakes; full and empty come from the occupancy count
   assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = mem[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage array, no reset needed on data
   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   // pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else if (ce_i) begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule

// ===== src/tbt_pkg.sv
package tbt_pkg;

   // receive checker states, one-hot
   typedef enum logic [2:0] {
      TBT_RX_IDLE = 3'h1,
      TBT_RX_HUNT = 3'h2,
      TBT_RX_LOCK = 3'h4
   } tbt_rx_state_t;

endpackage

// ===== src/tbt_regs.svh
// Summary of operation
// - transmit generator and receive checker of each port are enabled separately.
// - bit 11 sets on backplane lock, clears on backplane receiver start rise.
// - rise of bit 10 reloads the backplane generator with the seed.
// - rise of bit 9 zeroes backplane visible count and mismatch counter; an error in that cycle still counts.
// - rise of bit 8 enables the backplane checker to hunt for the seed.
// - an enabled unlocked checker hunts for the seed, then locks and flags it.
// - a locked checker counts every received bit unequal to its reference.
// - with receiver start low, comparison stops and the count holds.
// - rise of bit 7 starts backplane transmission; bit 7 low stops it.
// - bit 6 picks backplane sequence length: one 2^23-1, zero 2^15-1.
// - bit 5 sets on local lock, clears on local receiver start rise.
// - rise of bit 4 reloads the local generator with the seed.
// - rise of bit 3 zeroes local visible count and mismatch counter; an error in that cycle still counts.
// - rise of bit 2 enables the local checker, working like the backplane one.
// - rise of bit 1 starts local transmission; bit 1 low stops it.
// - bit 0 picks local sequence length: one 2^23-1, zero 2^15-1.
`ifndef TBT_REGS_SVH
`define TBT_REGS_SVH

// control register address and reset value
`define TBT_CTRL_OFFSET 16'h0002
`define TBT_CTRL_RESET 16'h0000
// writable bits: 10:6 and 4:0; lock flags and reserved bits excluded
`define TBT_CTRL_WMASK 16'h07DF

// each port owns a six-bit field; backplane field above the local one
`define TBT_FLD_W 6
`define TBT_BP_BASE 6
`define TBT_LOC_BASE 0
// bit positions inside a port field
`define TBT_F_LOCK 5
`define TBT_F_SEED 4
`define TBT_F_CLR 3
`define TBT_F_RXS 2
`define TBT_F_TXS 1
`define TBT_F_LEN 0

// sequence taps, window form (index 0 is the newest bit)
`define TBT_LONG_TAP_A 22
`define TBT_LONG_TAP_B 17
`define TBT_SHORT_TAP_A 14
`define TBT_SHORT_TAP_B 13
`define TBT_SEQ_W 23

// seed shared by generator and checker reference
`define TBT_SEED 23'h7FFFFF

// default buffer depth in the transmit path
`define TBT_FIFO_DEPTH 16

`endif

// ===== tb/tbt_ber_tester_chk.sv
`timescale 1ns/1ns
`include "tbt_regs.svh"
module tbt_ber_tester_chk #(
   parameter int ADDR_W = 16,
   parameter int CNT_W = 16
) (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic ce_i, // clock enable
   input wire logic [ADDR_W-1:0] addr_i, // register address
   input wire logic [15:0] wdata_i, // write data
   input wire logic wr_en_i, // write strobe
   input wire logic rd_en_i, // read strobe
   input wire logic [15:0] rdata_o, // read data
   input wire logic bp_tx_ready_i, // backplane slot ready
   input wire logic loc_tx_ready_i, // local slot ready
   input wire logic bp_tx_valid_o, // backplane bit valid
   input wire logic loc_tx_valid_o, // local bit valid
   input wire logic [CNT_W-1:0] bp_error_count_o, // backplane count
   input wire logic [CNT_W-1:0] loc_error_count_o, // local count
   input wire logic bp_rx_locked_o, // backplane lock
   input wire logic loc_rx_locked_o // local lock
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   logic [15:0] ctrl_q; // writable control bits as last written
   logic wr_ctl;
   logic rd_ctl;
   // accesses that reach the control register
   assign wr_ctl = ce_i && wr_en_i && addr_i == ADDR_W'(`TBT_CTRL_OFFSET);
   assign rd_ctl = ce_i && rd_en_i && addr_i == ADDR_W'(`TBT_CTRL_OFFSET);

   // mirror kept here so the checks can see edges of each start bit
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_q <= 16'h0000;
      end else if (wr_ctl) begin
         ctrl_q <= wdata_i & `TBT_CTRL_WMASK;
      end
   end

   reserved_zero_a: assert property (rd_ctl |=> rdata_o[15:12] == 4'h0)
      else $error("reserved control bits read nonzero");
   ctrl_readback_a: assert property (rd_ctl |=> (rdata_o & 16'h07DF) == $past(ctrl_q))
      else $error("control readback differs from written value");
   lock_mirror_a: assert property (rd_ctl |=> rdata_o[11] == $past(bp_rx_locked_o) && rdata_o[5] == $past(loc_rx_locked_o))
      else $error("lock bits in control read differ from lock flags");
   bp_lock_clear_a: assert property (wr_ctl && wdata_i[8] && !ctrl_q[8] |=> !bp_rx_locked_o [*8])
      else $error("backplane lock not cleared by receiver start");
   loc_lock_clear_a: assert property (wr_ctl && wdata_i[2] && !ctrl_q[2] |=> !loc_rx_locked_o [*8])
      else $error("local lock not cleared by receiver start");
   lock_cause_a: assert property ($rose(bp_rx_locked_o) |-> $past(ctrl_q[8]))
      else $error("backplane locked while receiver disabled");
   bp_clear_zero_a: assert property (wr_ctl && wdata_i[9] && !ctrl_q[9] |=> bp_error_count_o == '0)
      else $error("backplane count not cleared");
   loc_clear_zero_a: assert property (wr_ctl && wdata_i[3] && !ctrl_q[3] |=> loc_error_count_o == '0)
      else $error("local count not cleared");
   bp_count_hold_a: assert property (!ctrl_q[8] && !$past(ctrl_q[8]) && !wr_ctl && !$past(wr_ctl) |=> $stable(bp_error_count_o))
      else $error("backplane count moved while receiver stopped");
   tx_valid_a: assert property ((!bp_tx_valid_o || $past(bp_tx_ready_i)) && (!loc_tx_valid_o || $past(loc_tx_ready_i)))
      else $error("test bit sent without slot ready");
   count_step_a: assert property ($changed(bp_error_count_o) && !$past(wr_ctl) && !$past(wr_ctl, 2) |-> bp_error_count_o == $past(bp_error_count_o) + CNT_W'(1))
      else $error("backplane count moved by other than one");
endmodule

bind tbt_ber_tester tbt_ber_tester_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_tbt_ber_tester_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o), .bp_tx_ready_i(bp_tx_ready_i),
   .loc_tx_ready_i(loc_tx_ready_i), .bp_tx_valid_o(bp_tx_valid_o), .loc_tx_valid_o(loc_tx_valid_o),
   .bp_error_count_o(bp_error_count_o), .loc_error_count_o(loc_error_count_o),
   .bp_rx_locked_o(bp_rx_locked_o), .loc_rx_locked_o(loc_rx_locked_o)
);

// ===== tb/tbt_ber_tester_tb.sv
`timescale 1ns/1ns
`include "tbt_regs.svh"
module tbt_ber_tester_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [15:0] rdata_o;
   logic [1:0] slow = 2'h0;
   logic [1:0] flip = 2'h0;
   wire [15:0] cnt_w [2]; // index 1 backplane, 0 local
   wire [1:0] rx_bit, rx_stb, tx_rdy, tx_bit, tx_vld, lock;
   logic txq [2][$]; // bits seen leaving each port
   int n_errors = 0;
   int checked = 0;

   // 250 MHz system clock
   always #2 clk_i = ~clk_i;

   tbt_ber_tester #(.CNT_W(16)) u_tbt_ber_tester (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
      .bp_rx_bit_i(rx_bit[1]), .bp_rx_stb_i(rx_stb[1]), .loc_rx_bit_i(rx_bit[0]), .loc_rx_stb_i(rx_stb[0]),
      .bp_tx_ready_i(tx_rdy[1]), .loc_tx_ready_i(tx_rdy[0]), .bp_tx_bit_o(tx_bit[1]), .bp_tx_valid_o(tx_vld[1]),
      .loc_tx_bit_o(tx_bit[0]), .loc_tx_valid_o(tx_vld[0]), .bp_error_count_o(cnt_w[1]),
      .loc_error_count_o(cnt_w[0]), .bp_rx_locked_o(lock[1]), .loc_rx_locked_o(lock[0])
   );

   // one far-end partner per port, looping the test stream back
   for (genvar g = 0; g < 2; g++) begin : g_far
      tbt_far_end u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow[g]), .flip_i(flip[g]),
         .tx_bit_i(tx_bit[g]), .tx_valid_i(tx_vld[g]), .tx_ready_o(tx_rdy[g]), .rx_bit_o(rx_bit[g]),
         .rx_stb_o(rx_stb[g]));
   end

   // record transmitted bits; negedge keeps clear of the launching edge
   always @(negedge clk_i) begin
      for (int p = 0; p < 2; p++) begin
         if (tx_vld[p] === 1'b1) txq[p].push_back(tx_bit[p]);
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      step(1);
      addr_i = a;
      wdata_i = d;
      wr_en_i = 1'b1;
      step(1);
      wr_en_i = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      step(1);
      addr_i = a;
      rd_en_i = 1'b1;
      step(1);
      rd_en_i = 1'b0;
      d = rdata_o;
   endtask

   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // full loopback session on one port: b is 1 for backplane
   task automatic run(input int b, input logic lng);
      int sh;
      logic [15:0] v;
      logic [15:0] base;
      logic [22:0] sd;
      logic e[$];
      sh = b * 6;
      base = 16'(lng) << sh;
      sd = `TBT_SEED;
      slow = {2{lng}}; // long runs also stall the slot
      wr(16'h0002, base | (16'h0004 << sh));
      txq[0].delete();
      txq[1].delete();
      // generator is reloaded as well, so the seed leads the stream whatever ran before
      wr(16'h0002, base | (16'h001E << sh));
      step(400);
      rd(16'h0002, v);
      cmp("lock set", base | (16'h003E << sh), v);
      cmp("lock pin", 16'h0001, 16'(lock[b]));
      for (int n = 0; n < 60; n++) begin
         if (n < (lng ? 23 : 15)) e.push_back(sd[(lng ? 22 : 14) - n]);
         else e.push_back(lng ? e[n - 23] ^ e[n - 18] : e[n - 15] ^ e[n - 14]);
      end
      for (int n = 0; n < 60; n++) cmp("tx bit", 16'(e[n]), 16'(txq[b][n]));
      cmp("other port idle", 16'h0000, 16'(txq[1 - b].size()));
      cmp("count clean", 16'h0000, cnt_w[b]);
      flip[b] = 1'b1;
      step(1);
      flip[b] = 1'b0;
      step(100);
      cmp("count one", 16'h0001, cnt_w[b]);
      wr(16'h0002, base | (16'h001E << sh));
      step(20);
      cmp("count held", 16'h0001, cnt_w[b]);
      wr(16'h0002, base | (16'h000A << sh));
      flip[b] = 1'b1;
      step(1);
      flip[b] = 1'b0;
      step(100);
      cmp("count frozen", 16'h0001, cnt_w[b]);
      rd(16'h0002, v);
      cmp("lock stands", base | (16'h002A << sh), v);
      wr(16'h0002, base | (16'h0002 << sh));
      wr(16'h0002, base | (16'h000A << sh));
      step(2);
      cmp("count cleared", 16'h0000, cnt_w[b]);
      wr(16'h0002, base | (16'h0004 << sh));
      rd(16'h0002, v);
      cmp("lock dropped", base | (16'h0004 << sh), v);
      cmp("lock pin low", 16'h0000, 16'(lock[b]));
      step(150);
      txq[b].delete();
      step(60);
      cmp("tx off", 16'h0000, 16'(txq[b].size()));
      wr(16'h0002, 16'h0000);
      step(50);
   endtask

   // watchdog: the whole run needs about 3840 cycles
   initial begin
      #100000;
      n_errors++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      end_of_test;
   end

   initial begin
      logic [15:0] v;
      repeat (4) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      rd(16'h0002, v);
      cmp("ctrl reset", 16'h0000, v);
      rd(16'h0003, v);
      cmp("unmapped read", 16'h0000, v);
      wr(16'h0002, 16'h07DF);
      rd(16'h0002, v);
      cmp("ctrl all set", 16'h07DF, v);
      wr(16'h0002, 16'h0000);
      wr(16'h0003, 16'h0FFF);
      rd(16'h0002, v);
      cmp("ctrl after stray", 16'h0000, v);
      step(200);
      run(1, 1'b0);
      run(1, 1'b1);
      run(0, 1'b0);
      run(0, 1'b1);
      end_of_test;
   end
endmodule

// ===== tb/tbt_far_end.sv
`timescale 1ns/1ns
module tbt_far_end (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic slow_i, // take a bit only one cycle in four
   input wire logic flip_i, // corrupt the next bit sent back
   input wire logic tx_bit_i, // bit from the tester
   input wire logic tx_valid_i, // bit valid
   output logic tx_ready_o, // slot free
   output logic rx_bit_o, // bit back to the tester
   output logic rx_stb_o // bit strobe
);
   logic q[$]; // bits in flight
   logic pend; // corruption waiting for the next bit
   int ph; // 0 set bit, 1 raise strobe, 2 lower strobe
   int cnt;
   // loop the stream back; three cycles a bit keeps strobe rises apart
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         q.delete();
         pend = 1'b0;
         ph = 0;
         cnt = 0;
         tx_ready_o <= #1 1'b0;
         rx_stb_o <= #1 1'b0;
         rx_bit_o <= #1 1'b0;
      end else begin
         cnt++;
         if (tx_valid_i) q.push_back(tx_bit_i);
         if (flip_i) pend = 1'b1;
         case (ph)
            0: begin
               if (q.size() > 0) begin
                  rx_bit_o <= #1 q.pop_front() ^ pend;
                  pend = 1'b0;
                  ph = 1;
               end else begin
                  rx_bit_o <= #1 ~rx_bit_o; // idle line never holds the last bit
               end
            end
            1: begin
               rx_stb_o <= #1 1'b1;
               ph = 2;
            end
            default: begin
               rx_stb_o <= #1 1'b0;
               ph = 0;
            end
         endcase
         tx_ready_o <= #1 (q.size() < 3) && !(slow_i && cnt % 4 != 0);
      end
   end
endmodule
